// *** hw/cgc_pkg.sv ***
// Constants shared by the clock generator control register block
package cgc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [1:0] CGC_OFS_CTRL1 = 2'h0;
  localparam logic [1:0] CGC_OFS_CTRL2 = 2'h1;
  localparam logic [1:0] CGC_OFS_STAT = 2'h2;

  // ----------------------------------------------------------------
  // Field positions, first control register
  // ----------------------------------------------------------------
  localparam int CGC_C1_GAIN = 7;
  localparam int CGC_C1_RANGE = 6;
  localparam int CGC_C1_EXT_REF_SOURCE_SEL = 5;
  localparam int CGC_C1_MODE_HI = 4;
  localparam int CGC_C1_MODE_LO = 3;
  localparam int CGC_C1_KEEP = 2;
  localparam int CGC_C1_CLOCK_LOSS_DETECT_OFF = 1;

  // ----------------------------------------------------------------
  // Field positions, second control register
  // ----------------------------------------------------------------
  localparam int CGC_C2_LOCK_LOSS_RESET_SEL = 7;
  localparam int CGC_C2_MULT_HI = 6;
  localparam int CGC_C2_MULT_LO = 4;
  localparam int CGC_C2_CLOCK_LOSS_RESET_SEL = 3;
  localparam int CGC_C2_DIV_HI = 2;
  localparam int CGC_C2_DIV_LO = 0;

  // ----------------------------------------------------------------
  // Field positions, status register
  // ----------------------------------------------------------------
  localparam int CGC_ST_MODE_HI = 7;
  localparam int CGC_ST_MODE_LO = 6;
  localparam int CGC_ST_REF_SOURCE_STATUS = 5;
  localparam int CGC_ST_LOCK_LOSS_FLAG = 4;
  localparam int CGC_ST_PEND = 3;
  localparam int CGC_ST_EXT_REF_STABLE_FLAG = 1;

  // ----------------------------------------------------------------
  // Clock modes and loop factors
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CGC_SELF_CLOCKED = 2'h0,
    CGC_INT_LOCKED = 2'h1,
    CGC_EXT_BYPASS = 2'h2,
    CGC_EXT_LOCKED = 2'h3
  } cgc_mode_t;

  localparam logic [6:0] CGC_P_LOW_RANGE = 7'h40;
  localparam logic [6:0] CGC_P_HIGH_RANGE = 7'h01;
  localparam logic [4:0] CGC_N_BASE = 5'h04;
  localparam logic [7:0] CGC_DIV_ONE = 8'h01;

  // Cycles for a mode, multiplier or divider write to reach the clock domain
  localparam logic [2:0] CGC_APPLY_CYCLES = 3'h4;
  localparam int CGC_NUM_PEND = 3;
  localparam int CGC_PEND_MODE = 0;
  localparam int CGC_PEND_MULT = 1;
  localparam int CGC_PEND_DIV = 2;

endpackage

// *** hw/cgc_clock_gen_ctrl.sv ***
// Control registers and mode sequencing of the internal clock generator
`timescale 1ns/1ps

// Summary of operation
// - Gain bit 7: 0 low power, 1 high gain noise immune oscillator.
// - Gain, range, reference source take only the first write after reset.
// - Range bit 6: 0 low range P=64, 1 high range P=1.
// - Range affects clock path only in external locked or bypass mode.
// - Reference bit 5: 0 external clock, 1 crystal oscillator.
// - Mode bits 4:3: 00 self, 01 int locked, 10 bypass, 11 ext locked.
// - Bypass mode applied only once external reference reports stable.
// - Off mode leaves the mode select field unchanged.
// - Mode, multiplier, divider writes dropped while previous write pending.
// - First mode write with upper bit 0 blocks upper bit 1 until reset.
// - Oscillator in off mode follows keep-on bit, mode, reference status.
// - Keep-on bit ignored when high gain and high range both set.
// - Bit 1 at 1 disables loss-of-clock detection.
// - Lock-loss action: 0 interrupt, 1 reset request.
// - Lock-loss request only while the lock-loss flag is set.
// - Multiplier code gives N = 4 + 2 * code.
// - Clock-loss action: 0 interrupt, 1 reset request.
// - Divider code gives division by two to the code.
// - External pin claimed only if first write selects an external mode.
// - Stable flag reads 1 only for a stable, fast enough reference.
// - Reset starts in self-clocked mode with the loop open.
module cgc_clock_gen_ctrl (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Generator status inputs
  input wire logic ext_ref_stable_flag_i,
  input wire logic lock_loss_flag_i,
  input wire logic clock_loss_i,
  input wire logic off_mode_i,
  input wire logic osc_enable_req_i,
  // Generator controls
  output logic [1:0] clock_mode_o,
  output logic osc_high_gain_sel_o,
  output logic range_high_o,
  output logic [6:0] loop_prescale_o,
  output logic ext_ref_source_sel_o,
  output logic ext_clock_pin_claim_o,
  output logic osc_run_o,
  output logic loop_open_o,
  output logic clock_loss_detect_en_o,
  output logic [4:0] loop_mult_n_o,
  output logic [7:0] output_div_o,
  // Event requests
  output logic lock_loss_irq_o,
  output logic lock_loss_rst_o,
  output logic clock_loss_irq_o,
  output logic clock_loss_rst_o
);

  // ----------------------------------------------------------------
  // Written fields
  // ----------------------------------------------------------------
  logic c1_written_r;
  logic mode_first_written_r;
  logic ext_pin_r;
  logic osc_high_gain_sel_r;
  logic range_high_r;
  logic ext_ref_source_sel_r;
  logic [1:0] clock_mode_sel_r;
  logic osc_keep_on_in_off_r;
  logic clock_loss_detect_off_r;
  logic lock_loss_reset_sel_r;
  logic [2:0] loop_multiplier_code_r;
  logic clock_loss_reset_sel_r;
  logic [2:0] output_divider_code_r;
  logic [1:0] mode_act_r;
  logic [2:0] mult_act_r;
  logic [2:0] div_act_r;
  logic [cgc_pkg::CGC_NUM_PEND-1:0] pend_busy;
  logic [cgc_pkg::CGC_NUM_PEND-1:0] pend_start;
  logic [cgc_pkg::CGC_NUM_PEND-1:0] pend_hold;
  logic [cgc_pkg::CGC_NUM_PEND-1:0] pend_done;
  logic wr_c1;
  logic wr_c2;
  logic [1:0] mode_wr;
  logic mode_wr_ok;
  logic ext_mode_act;
  logic osc_run_nxt;
  logic [7:0] rdata_nxt;

  assign wr_c1 = reg_wr_i && (reg_addr_i == cgc_pkg::CGC_OFS_CTRL1);
  assign wr_c2 = reg_wr_i && (reg_addr_i == cgc_pkg::CGC_OFS_CTRL2);
  assign mode_wr = reg_wdata_i[cgc_pkg::CGC_C1_MODE_HI:cgc_pkg::CGC_C1_MODE_LO];
  assign ext_mode_act = mode_act_r[1];

  // Upper mode bit refused once the pin was left to other functions
  assign mode_wr_ok = !pend_busy[cgc_pkg::CGC_PEND_MODE] &&
    !(mode_first_written_r && !ext_pin_r && mode_wr[1]);
  assign pend_start[cgc_pkg::CGC_PEND_MODE] = wr_c1 && mode_wr_ok;
  assign pend_start[cgc_pkg::CGC_PEND_MULT] = wr_c2 &&
    !pend_busy[cgc_pkg::CGC_PEND_MULT];
  assign pend_start[cgc_pkg::CGC_PEND_DIV] = wr_c2 &&
    !pend_busy[cgc_pkg::CGC_PEND_DIV];
  // Bypass waits for a stable external reference
  assign pend_hold[cgc_pkg::CGC_PEND_MODE] =
    (clock_mode_sel_r == cgc_pkg::CGC_EXT_BYPASS) &&
    !ext_ref_stable_flag_i;
  assign pend_hold[cgc_pkg::CGC_PEND_MULT] = 1'b0;
  assign pend_hold[cgc_pkg::CGC_PEND_DIV] = 1'b0;

  // ----------------------------------------------------------------
  // Write completion trackers
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < cgc_pkg::CGC_NUM_PEND; i++)
    begin : g_pend
      logic [2:0] cnt_r;
      always_ff @(posedge clk_sys_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
          cnt_r <= 3'h0;
        else if (pend_start[i])
          cnt_r <= cgc_pkg::CGC_APPLY_CYCLES;
        else if (cnt_r > 3'h1 || (cnt_r == 3'h1 && !pend_hold[i]))
          cnt_r <= cnt_r - 3'h1;
      end
      assign pend_busy[i] = (cnt_r != 3'h0);
      assign pend_done[i] = (cnt_r == 3'h1) && !pend_hold[i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // First control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      c1_written_r <= 1'b0;
      osc_high_gain_sel_r <= 1'b0;
      range_high_r <= 1'b0;
      ext_ref_source_sel_r <= 1'b0;
      ext_pin_r <= 1'b0;
    end
    else if (wr_c1 && !c1_written_r)
    begin
      c1_written_r <= 1'b1;
      osc_high_gain_sel_r <= reg_wdata_i[cgc_pkg::CGC_C1_GAIN];
      range_high_r <= reg_wdata_i[cgc_pkg::CGC_C1_RANGE];
      ext_ref_source_sel_r <= reg_wdata_i[cgc_pkg::CGC_C1_EXT_REF_SOURCE_SEL];
      ext_pin_r <= mode_wr[1];
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      clock_mode_sel_r <= cgc_pkg::CGC_SELF_CLOCKED;
      mode_first_written_r <= 1'b0;
    end
    else if (pend_start[cgc_pkg::CGC_PEND_MODE])
    begin
      // Off mode has no path here, so the field keeps its value
      clock_mode_sel_r <= mode_wr;
      mode_first_written_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      osc_keep_on_in_off_r <= 1'b0;
      clock_loss_detect_off_r <= 1'b0;
    end
    else if (wr_c1)
    begin
      osc_keep_on_in_off_r <= reg_wdata_i[cgc_pkg::CGC_C1_KEEP];
      clock_loss_detect_off_r <= reg_wdata_i[cgc_pkg::CGC_C1_CLOCK_LOSS_DETECT_OFF];
    end
  end

  // ----------------------------------------------------------------
  // Second control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lock_loss_reset_sel_r <= 1'b0;
      clock_loss_reset_sel_r <= 1'b0;
    end
    else if (wr_c2)
    begin
      lock_loss_reset_sel_r <= reg_wdata_i[cgc_pkg::CGC_C2_LOCK_LOSS_RESET_SEL];
      clock_loss_reset_sel_r <= reg_wdata_i[cgc_pkg::CGC_C2_CLOCK_LOSS_RESET_SEL];
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      loop_multiplier_code_r <= 3'h0;
    else if (pend_start[cgc_pkg::CGC_PEND_MULT])
      loop_multiplier_code_r <=
        reg_wdata_i[cgc_pkg::CGC_C2_MULT_HI:cgc_pkg::CGC_C2_MULT_LO];
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      output_divider_code_r <= 3'h0;
    else if (pend_start[cgc_pkg::CGC_PEND_DIV])
      output_divider_code_r <=
        reg_wdata_i[cgc_pkg::CGC_C2_DIV_HI:cgc_pkg::CGC_C2_DIV_LO];
  end

  // ----------------------------------------------------------------
  // Applied settings
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mode_act_r <= cgc_pkg::CGC_SELF_CLOCKED;
      mult_act_r <= 3'h0;
      div_act_r <= 3'h0;
    end
    else
    begin
      if (pend_done[cgc_pkg::CGC_PEND_MODE])
        mode_act_r <= clock_mode_sel_r;
      if (pend_done[cgc_pkg::CGC_PEND_MULT])
        mult_act_r <= loop_multiplier_code_r;
      if (pend_done[cgc_pkg::CGC_PEND_DIV])
        div_act_r <= output_divider_code_r;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator run control
  // ----------------------------------------------------------------
  always_comb
  begin
    osc_run_nxt = ext_pin_r && clock_mode_sel_r[1];
    if (off_mode_i)
    begin
      if (osc_high_gain_sel_r && range_high_r)
        osc_run_nxt = ext_pin_r;
      else if (osc_keep_on_in_off_r)
        osc_run_nxt = clock_mode_sel_r[1] && ext_ref_source_sel_r;
      else
        osc_run_nxt = osc_enable_req_i && ext_ref_source_sel_r &&
          (clock_mode_sel_r == cgc_pkg::CGC_EXT_BYPASS);
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      clock_mode_o <= cgc_pkg::CGC_SELF_CLOCKED;
      osc_high_gain_sel_o <= 1'b0;
      range_high_o <= 1'b0;
      loop_prescale_o <= cgc_pkg::CGC_P_HIGH_RANGE;
      ext_ref_source_sel_o <= 1'b0;
      ext_clock_pin_claim_o <= 1'b0;
      osc_run_o <= 1'b0;
      loop_open_o <= 1'b1;
      clock_loss_detect_en_o <= 1'b1;
      loop_mult_n_o <= cgc_pkg::CGC_N_BASE;
      output_div_o <= cgc_pkg::CGC_DIV_ONE;
    end
    else
    begin
      clock_mode_o <= mode_act_r;
      osc_high_gain_sel_o <= osc_high_gain_sel_r;
      range_high_o <= range_high_r && ext_mode_act;
      loop_prescale_o <= (ext_mode_act && !range_high_r) ?
        cgc_pkg::CGC_P_LOW_RANGE : cgc_pkg::CGC_P_HIGH_RANGE;
      ext_ref_source_sel_o <= ext_ref_source_sel_r;
      ext_clock_pin_claim_o <= ext_pin_r;
      osc_run_o <= osc_run_nxt;
      loop_open_o <= !mode_act_r[0];
      clock_loss_detect_en_o <= !clock_loss_detect_off_r;
      loop_mult_n_o <= cgc_pkg::CGC_N_BASE +
        {1'b0, mult_act_r, 1'b0};
      output_div_o <= cgc_pkg::CGC_DIV_ONE << div_act_r;
    end
  end

  // ----------------------------------------------------------------
  // Loss requests
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lock_loss_irq_o <= 1'b0;
      lock_loss_rst_o <= 1'b0;
      clock_loss_irq_o <= 1'b0;
      clock_loss_rst_o <= 1'b0;
    end
    else
    begin
      lock_loss_irq_o <= lock_loss_flag_i && !lock_loss_reset_sel_r;
      lock_loss_rst_o <= lock_loss_flag_i && lock_loss_reset_sel_r;
      clock_loss_irq_o <= clock_loss_i && !clock_loss_detect_off_r &&
        !clock_loss_reset_sel_r;
      clock_loss_rst_o <= clock_loss_i && !clock_loss_detect_off_r &&
        clock_loss_reset_sel_r;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = 8'h00;
    unique case (reg_addr_i)
      cgc_pkg::CGC_OFS_CTRL1:
      begin
        rdata_nxt[cgc_pkg::CGC_C1_GAIN] = osc_high_gain_sel_r;
        rdata_nxt[cgc_pkg::CGC_C1_RANGE] = range_high_r;
        rdata_nxt[cgc_pkg::CGC_C1_EXT_REF_SOURCE_SEL] = ext_ref_source_sel_r;
        rdata_nxt[cgc_pkg::CGC_C1_MODE_HI:cgc_pkg::CGC_C1_MODE_LO] =
          clock_mode_sel_r;
        rdata_nxt[cgc_pkg::CGC_C1_KEEP] = osc_keep_on_in_off_r;
        rdata_nxt[cgc_pkg::CGC_C1_CLOCK_LOSS_DETECT_OFF] = clock_loss_detect_off_r;
      end
      cgc_pkg::CGC_OFS_CTRL2:
      begin
        rdata_nxt[cgc_pkg::CGC_C2_LOCK_LOSS_RESET_SEL] = lock_loss_reset_sel_r;
        rdata_nxt[cgc_pkg::CGC_C2_MULT_HI:cgc_pkg::CGC_C2_MULT_LO] =
          loop_multiplier_code_r;
        rdata_nxt[cgc_pkg::CGC_C2_CLOCK_LOSS_RESET_SEL] = clock_loss_reset_sel_r;
        rdata_nxt[cgc_pkg::CGC_C2_DIV_HI:cgc_pkg::CGC_C2_DIV_LO] =
          output_divider_code_r;
      end
      cgc_pkg::CGC_OFS_STAT:
      begin
        rdata_nxt[cgc_pkg::CGC_ST_MODE_HI:cgc_pkg::CGC_ST_MODE_LO] =
          mode_act_r;
        rdata_nxt[cgc_pkg::CGC_ST_REF_SOURCE_STATUS] = ext_ref_source_sel_r;
        rdata_nxt[cgc_pkg::CGC_ST_LOCK_LOSS_FLAG] = lock_loss_flag_i;
        rdata_nxt[cgc_pkg::CGC_ST_PEND] = |pend_busy;
        rdata_nxt[cgc_pkg::CGC_ST_EXT_REF_STABLE_FLAG] = ext_ref_stable_flag_i;
      end
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= reg_rd_i ? rdata_nxt : 8'h00;
  end

endmodule

// *** tb/cgc_clock_gen_ctrl_chk.sv ***
// Assertion checker for the clock generator control block ports
`timescale 1ns/1ps
module cgc_clock_gen_ctrl_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Status inputs
  input wire logic ext_ref_stable_flag_i,
  input wire logic lock_loss_flag_i,
  input wire logic clock_loss_i,
  // Generator controls
  input wire logic [1:0] clock_mode_o,
  input wire logic osc_high_gain_sel_o,
  input wire logic range_high_o,
  input wire logic [6:0] loop_prescale_o,
  input wire logic ext_ref_source_sel_o,
  input wire logic ext_clock_pin_claim_o,
  input wire logic loop_open_o,
  input wire logic clock_loss_detect_en_o,
  input wire logic [4:0] loop_mult_n_o,
  input wire logic [7:0] output_div_o,
  // Event requests
  input wire logic lock_loss_irq_o,
  input wire logic lock_loss_rst_o,
  input wire logic clock_loss_irq_o,
  input wire logic clock_loss_rst_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  // Read data may only appear in the cycle after a read strobe
  sequence s_no_read;
    !reg_rd_i ##1 1'b1;
  endsequence
  sequence s_bypass_entry;
    $changed(clock_mode_o) && (clock_mode_o == cgc_pkg::CGC_EXT_BYPASS);
  endsequence

  rdata_idle_a:
    assert property (s_no_read |-> reg_rdata_o == 8'h00)
      else $error("read data outside read cycle");
  lock_req_cause_a:
    assert property ((lock_loss_irq_o || lock_loss_rst_o) |->
      $past(lock_loss_flag_i)) else $error("lock request without flag");
  lock_req_excl_a:
    assert property (!(lock_loss_irq_o && lock_loss_rst_o))
      else $error("lock loss irq and reset together");
  clk_req_cause_a:
    assert property ((clock_loss_irq_o || clock_loss_rst_o) |->
      $past(clock_loss_i) && !(clock_loss_irq_o && clock_loss_rst_o))
      else $error("bad clock loss request");
  clk_detect_gate_a:
    assert property ((clock_loss_irq_o || clock_loss_rst_o) |->
      clock_loss_detect_en_o || $past(clock_loss_detect_en_o))
      else $error("clock loss request with detection off");
  range_gate_a:
    assert property (range_high_o |-> clock_mode_o[1])
      else $error("range active outside external modes");
  prescale_val_a:
    assert property (loop_prescale_o == ((clock_mode_o[1] && !range_high_o)
      ? cgc_pkg::CGC_P_LOW_RANGE : cgc_pkg::CGC_P_HIGH_RANGE))
      else $error("prescale does not match mode and range");
  loop_open_a:
    assert property (loop_open_o == !clock_mode_o[0])
      else $error("loop open state wrong for mode");
  mult_span_a:
    assert property (loop_mult_n_o >= 5'h04 && loop_mult_n_o <= 5'h12 &&
      !loop_mult_n_o[0]) else $error("multiplier outside 4 to 18 even");
  div_power_a:
    assert property ($onehot(output_div_o))
      else $error("divider not a power of two");
  bypass_wait_a:
    assert property (s_bypass_entry |-> $past(ext_ref_stable_flag_i) ||
      $past(ext_ref_stable_flag_i, 2)) else $error("bypass before stable");
  claim_gate_a:
    assert property (!ext_clock_pin_claim_o |-> !clock_mode_o[1])
      else $error("external mode without claimed pin");
  claim_sticky_a:
    assert property (!$fell(ext_clock_pin_claim_o))
      else $error("pin claim dropped without reset");
  write_once_a:
    assert property (!$fell(osc_high_gain_sel_o) &&
      !$fell(ext_ref_source_sel_o)) else $error("write-once field changed");
endmodule

// *** tb/cgc_clock_gen_ctrl_tb.sv ***
// Self-checking bench for the clock generator control block
`timescale 1ns/1ps
module cgc_clock_gen_ctrl_tb;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] reg_addr_i = 2'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic ext_ref_stable_flag_i = 1'b0;
  logic lock_loss_flag_i = 1'b0;
  logic clock_loss_i = 1'b0;
  logic off_mode_i = 1'b0;
  logic osc_enable_req_i = 1'b0;
  logic [7:0] reg_rdata_o, output_div_o;
  logic [1:0] clock_mode_o;
  logic [6:0] loop_prescale_o;
  logic [4:0] loop_mult_n_o;
  logic osc_high_gain_sel_o, range_high_o, ext_ref_source_sel_o;
  logic ext_clock_pin_claim_o, osc_run_o, loop_open_o;
  logic clock_loss_detect_en_o, lock_loss_irq_o, lock_loss_rst_o;
  logic clock_loss_irq_o, clock_loss_rst_o;
  int n_errors = 0;
  int n_tests = 0;
  int n_cycles = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  cgc_clock_gen_ctrl dut (
    .clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .ext_ref_stable_flag_i, .lock_loss_flag_i,
    .clock_loss_i, .off_mode_i, .osc_enable_req_i, .clock_mode_o,
    .osc_high_gain_sel_o, .range_high_o, .loop_prescale_o,
    .ext_ref_source_sel_o, .ext_clock_pin_claim_o, .osc_run_o,
    .loop_open_o, .clock_loss_detect_en_o, .loop_mult_n_o, .output_div_o,
    .lock_loss_irq_o, .lock_loss_rst_o, .clock_loss_irq_o,
    .clock_loss_rst_o
  );

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ends just after an edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("read data", reg_rdata_o, exp);
  endtask

  task automatic do_reset();
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    cyc(1);
  endtask

  // A hang shows up as a count past the expected run of a few hundred
  always @(posedge clk_sys_i)
  begin
    n_cycles++;
    if (n_cycles == 3000)
    begin
      n_errors++;
      finish_test();
    end
  end

  initial
  begin
    do_reset();
    chk("mode", 8'(clock_mode_o), 8'h00);
    chk("loop open", 8'(loop_open_o), 8'h01);
    chk("prescale", 8'(loop_prescale_o), 8'h01);
    chk("mult", 8'(loop_mult_n_o), 8'h04);
    chk("div", output_div_o, 8'h01);
    chk("detect", 8'(clock_loss_detect_en_o), 8'h01);
    rd(2'h0, 8'h00);
    // Second write lands while the first mode write is still pending
    wr(2'h0, 8'hBE);
    wr(2'h0, 8'h48);
    rd(2'h0, 8'hB8);
    cyc(8);
    chk("mode", 8'(clock_mode_o), 8'h03);
    chk("gain", 8'(osc_high_gain_sel_o), 8'h01);
    chk("range", 8'(range_high_o), 8'h00);
    chk("prescale", 8'(loop_prescale_o), 8'h40);
    chk("ref sel", 8'(ext_ref_source_sel_o), 8'h01);
    chk("claim", 8'(ext_clock_pin_claim_o), 8'h01);
    chk("loop open", 8'(loop_open_o), 8'h00);
    rd(2'h2, 8'hE0);
    for (int c = 0; c < 8; c++)
    begin
      wr(2'h1, {1'b0, 3'(c), 1'b0, 3'(c)});
      cyc(8);
      chk("mult", 8'(loop_mult_n_o), 8'(4 + 2 * c));
      chk("div", output_div_o, 8'(1 << c));
    end
    wr(2'h1, 8'h33);
    wr(2'h1, 8'h55);
    wr(2'h3, 8'hFF);
    rd(2'h1, 8'h33);
    cyc(8);
    chk("mult", 8'(loop_mult_n_o), 8'h0A);
    chk("div", output_div_o, 8'h08);
    @(posedge clk_sys_i);
    lock_loss_flag_i <= 1'b1;
    clock_loss_i <= 1'b1;
    cyc(3);
    chk("lock irq", 8'(lock_loss_irq_o), 8'h01);
    chk("clk irq", 8'(clock_loss_irq_o), 8'h01);
    wr(2'h1, 8'hBB);
    cyc(3);
    chk("lock rst", 8'(lock_loss_rst_o), 8'h01);
    chk("lock irq", 8'(lock_loss_irq_o), 8'h00);
    chk("clk rst", 8'(clock_loss_rst_o), 8'h01);
    @(posedge clk_sys_i);
    lock_loss_flag_i <= 1'b0;
    cyc(3);
    chk("lock rst", 8'(lock_loss_rst_o), 8'h00);
    wr(2'h0, 8'hBA);
    cyc(6);
    chk("detect", 8'(clock_loss_detect_en_o), 8'h00);
    chk("clk rst", 8'(clock_loss_rst_o), 8'h00);
    @(posedge clk_sys_i);
    clock_loss_i <= 1'b0;
    // Bypass is requested before the reference reports stable
    wr(2'h0, 8'h10);
    cyc(10);
    chk("mode", 8'(clock_mode_o), 8'h03);
    @(posedge clk_sys_i);
    ext_ref_stable_flag_i <= 1'b1;
    cyc(8);
    chk("mode", 8'(clock_mode_o), 8'h02);
    chk("loop open", 8'(loop_open_o), 8'h01);
    chk("prescale", 8'(loop_prescale_o), 8'h40);
    @(posedge clk_sys_i);
    off_mode_i <= 1'b1;
    cyc(3);
    chk("osc run", 8'(osc_run_o), 8'h00);
    chk("mode", 8'(clock_mode_o), 8'h02);
    @(posedge clk_sys_i);
    osc_enable_req_i <= 1'b1;
    cyc(3);
    chk("osc run", 8'(osc_run_o), 8'h01);
    @(posedge clk_sys_i);
    osc_enable_req_i <= 1'b0;
    wr(2'h0, 8'h14);
    cyc(8);
    chk("osc run", 8'(osc_run_o), 8'h01);
    rd(2'h0, 8'hB4);
    @(posedge clk_sys_i);
    off_mode_i <= 1'b0;
    // Internal first write leaves the pin free and blocks external modes
    do_reset();
    chk("claim", 8'(ext_clock_pin_claim_o), 8'h00);
    wr(2'h0, 8'h08);
    cyc(8);
    wr(2'h0, 8'hF8);
    rd(2'h0, 8'h08);
    cyc(8);
    chk("mode", 8'(clock_mode_o), 8'h01);
    chk("claim", 8'(ext_clock_pin_claim_o), 8'h00);
    chk("gain", 8'(osc_high_gain_sel_o), 8'h00);
    // High gain with high range overrides the keep-on bit in off mode
    do_reset();
    wr(2'h0, 8'hD0);
    cyc(8);
    chk("range", 8'(range_high_o), 8'h01);
    chk("prescale", 8'(loop_prescale_o), 8'h01);
    rd(2'h2, 8'h82);
    @(posedge clk_sys_i);
    off_mode_i <= 1'b1;
    cyc(3);
    chk("osc run", 8'(osc_run_o), 8'h01);
    finish_test();
  end
endmodule

bind cgc_clock_gen_ctrl cgc_clock_gen_ctrl_chk chk_i (
  .clk_sys_i, .sys_rst_i, .reg_rd_i, .reg_rdata_o, .ext_ref_stable_flag_i,
  .lock_loss_flag_i, .clock_loss_i, .clock_mode_o, .osc_high_gain_sel_o,
  .range_high_o, .loop_prescale_o, .ext_ref_source_sel_o,
  .ext_clock_pin_claim_o, .loop_open_o, .clock_loss_detect_en_o,
  .loop_mult_n_o, .output_div_o, .lock_loss_irq_o, .lock_loss_rst_o,
  .clock_loss_irq_o, .clock_loss_rst_o
);
